// File: design/sleep_tick_if.sv
// Slow-clock tick and calibration hand-off between the timer and its tick source
`timescale 1ns/1ps
interface sleep_tick_if;
	logic tick;
	logic cal_valid;
	modport source (output tick, output cal_valid);
	modport sink (input tick, input cal_valid);
endinterface : sleep_tick_if

// File: design/sleep_timer_params.svh
// Constants of the sleep wake-up timer
`ifndef SLEEP_TIMER_PARAMS_SVH
`define SLEEP_TIMER_PARAMS_SVH
`define ST_CNT_W 31
`define ST_SLICE_W 16
`define ST_RES_STEP 5
`define ST_CLEAR_VALUE 31'h0000_0004
`define ST_MANT_RESET 16'h876B
`define ST_RC_DIV 750
`define ST_XTAL_HZ 32768
`define ST_SLEEP_MIN_TICKS 384
`define ST_MODE_ACTIVE 2'h0
`define ST_MODE_PM0 2'h0
`define ST_MODE_PM1 2'h1
`define ST_MODE_PM2 2'h2
`define ST_MODE_PM3 2'h3
`endif

// File: design/sleep_timer_pkg.sv
// Types of the sleep wake-up timer
package sleep_timer_pkg;
	typedef enum logic [1:0] {
		st_active_t_val = 2'h0,
		st_sleep_t_val = 2'h1
	} power_state_t;
endpackage : sleep_timer_pkg

// File: design/sleep_wakeup_timer.sv
// Sleep wake-up timer top level
// How it works
// - A 31-bit free-running counter advances on each rising edge of the selected slow clock.
// - Only a resolution-selected 16-bit slice is shown and compared.
// - Select 0..3 picks bits 15:0, 20:5, 25:10, 30:15.
// - Slow clock is the 32.768 kHz crystal or RC at reference/750.
// - Counter runs in every mode; events occur only in the three light power-down modes.
// - Event 0 in a light power-down mode returns the chip active.
// - Event period is mantissa times two to five times the select.
// - Low count byte updates at the rate set by the select.
// - Clear loads the counter with four; the slice reads four at select 0, zero otherwise.
// - RC calibrates while crystal runs in active mode or lightest sleep.
// - In deeper light modes the RC keeps its last calibration.
// - Each Event 0 sets the wake pending flag.
// - With event irq enable, Event 0 also sets the CPU sleep flag.
// - CPU sleep flag with its enable raises the interrupt request.
// - Interrupt request is blocked unless the mode select holds zero.
`timescale 1ns/1ps
`include "sleep_timer_params.svh"
module sleep_wakeup_timer
	import sleep_timer_pkg::*;
#(
	parameter int CNT_W = `ST_CNT_W
) (
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic i_ce,
	input wire logic i_xtal_clk,
	input wire logic i_rc_clk,
	input wire logic i_use_rc,
	input wire logic i_hs_xosc_on,
	input wire logic i_sleeping,
	input wire logic [1:0] i_power_mode,
	input wire logic [1:0] i_sleep_resolution_select,
	input wire logic [15:0] i_wake_event_mantissa,
	input wire logic i_counter_clear,
	input wire logic i_wake_event_irq_enable,
	input wire logic i_cpu_sleep_irq_enable,
	input wire logic i_pending_clear,
	input wire logic i_cpu_flag_clear,
	output logic [7:0] o_sleep_count_low_byte,
	output logic [15:0] o_sleep_count_slice,
	output logic o_wake_event_pending,
	output logic o_cpu_sleep_irq_flag,
	output logic o_irq,
	output logic o_wake_to_active,
	output logic o_event_pulse,
	output logic o_rc_cal_valid
);
	initial begin
		if (CNT_W != `ST_CNT_W) $error("sleep_wakeup_timer: counter width must be 31");
	end
	// ************************************************************
	// Helpers
	// ************************************************************
	function automatic logic [15:0] slice_of(input logic [30:0] c, input logic [1:0] r);
		logic [30:0] sh;
		sh = c >> (`ST_RES_STEP * r);
		slice_of = sh[15:0];
	endfunction : slice_of
	function automatic logic light_mode(input logic s, input logic [1:0] m);
		light_mode = s & (m != `ST_MODE_PM3);
	endfunction : light_mode
	sleep_tick_if tick_bus ();
	// ************************************************************
	// Slow clock source
	// ************************************************************
	slow_tick_gen u_tick (
		.i_clk(i_clk),
		.i_nrst(i_nrst),
		.i_ce(i_ce),
		.i_xtal_clk(i_xtal_clk),
		.i_rc_clk(i_rc_clk),
		.i_use_rc(i_use_rc),
		.i_calibrate(i_hs_xosc_on & (~i_sleeping | (i_power_mode == `ST_MODE_PM0))),
		.tick_if(tick_bus.source)
	);
	logic [30:0] cnt_reg, cnt_next;
	logic [15:0] slice_reg, slice_next;
	logic pend_reg, pend_next;
	logic flag_reg, flag_next;
	logic irq_reg, irq_next;
	logic wake_reg, wake_next;
	logic evt_reg, evt_next;
	logic cal_reg, cal_next;
	logic hit;
	power_state_t pst;
	// ************************************************************
	// Counter, compare and flags
	// ************************************************************
	always_comb begin
		pst = i_sleeping ? st_sleep_t_val : st_active_t_val;
		cnt_next = cnt_reg;
		hit = 1'b0;
		if (i_counter_clear) begin
			cnt_next = `ST_CLEAR_VALUE;
		end else if (tick_bus.tick) begin
			cnt_next = cnt_reg + 31'h1;
			// Compare on the new slice so the event lands on the tick edge
			hit = light_mode(i_sleeping, i_power_mode) &&
				(slice_of(cnt_next, i_sleep_resolution_select) == i_wake_event_mantissa);
		end
		slice_next = slice_of(cnt_next, i_sleep_resolution_select);
		// Set wins over a clear in the same cycle
		pend_next = hit | (pend_reg & ~i_pending_clear);
		flag_next = (hit & i_wake_event_irq_enable) | (flag_reg & ~i_cpu_flag_clear);
		irq_next = flag_next & i_cpu_sleep_irq_enable
			& (i_power_mode == `ST_MODE_ACTIVE);
		wake_next = hit & (pst == st_sleep_t_val);
		evt_next = hit;
		cal_next = tick_bus.cal_valid;
	end
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			cnt_reg <= 31'h0;
			slice_reg <= 16'h0;
			pend_reg <= 1'b0;
			flag_reg <= 1'b0;
			irq_reg <= 1'b0;
			wake_reg <= 1'b0;
			evt_reg <= 1'b0;
			cal_reg <= 1'b0;
		end else if (i_ce) begin
			cnt_reg <= cnt_next;
			slice_reg <= slice_next;
			pend_reg <= pend_next;
			flag_reg <= flag_next;
			irq_reg <= irq_next;
			wake_reg <= wake_next;
			evt_reg <= evt_next;
			cal_reg <= cal_next;
		end
	end
	assign o_sleep_count_low_byte = slice_reg[7:0];
	assign o_sleep_count_slice = slice_reg;
	assign o_wake_event_pending = pend_reg;
	assign o_cpu_sleep_irq_flag = flag_reg;
	assign o_irq = irq_reg;
	assign o_wake_to_active = wake_reg;
	assign o_event_pulse = evt_reg;
	assign o_rc_cal_valid = cal_reg;
	// ************************************************************
	// Checks
	// ************************************************************
	sequence s_hit_seen;
		i_ce && evt_reg;
	endsequence
	a_clear_loads_four: assert property (@(posedge i_clk) disable iff (!i_nrst)
		i_ce && i_counter_clear |=> cnt_reg == `ST_CLEAR_VALUE)
		else $error("counter clear did not load four");
	a_tick_advances: assert property (@(posedge i_clk) disable iff (!i_nrst)
		i_ce && !i_counter_clear && tick_bus.tick |=> cnt_reg == $past(cnt_reg) + 31'h1)
		else $error("counter did not advance on tick");
	a_hold_no_tick: assert property (@(posedge i_clk) disable iff (!i_nrst)
		!i_counter_clear && !tick_bus.tick |=> $stable(cnt_reg))
		else $error("counter moved without tick");
	a_slice_select: assert property (@(posedge i_clk) disable iff (!i_nrst)
		i_ce |=> slice_reg == slice_of(cnt_reg, $past(i_sleep_resolution_select)))
		else $error("slice does not match select");
	a_pending_sets: assert property (@(posedge i_clk) disable iff (!i_nrst)
		s_hit_seen |-> pend_reg)
		else $error("event without pending flag");
	a_pending_holds: assert property (@(posedge i_clk) disable iff (!i_nrst)
		pend_reg && !i_pending_clear |=> pend_reg)
		else $error("pending flag dropped");
	a_cpu_flag_mask: assert property (@(posedge i_clk) disable iff (!i_nrst)
		i_ce && evt_next && !i_wake_event_irq_enable && !flag_reg |=> !flag_reg)
		else $error("cpu flag set while masked");
	a_irq_blocked: assert property (@(posedge i_clk) disable iff (!i_nrst)
		i_ce && i_power_mode != `ST_MODE_ACTIVE |=> !irq_reg)
		else $error("irq not blocked by mode");
	a_wake_in_sleep: assert property (@(posedge i_clk) disable iff (!i_nrst)
		o_wake_to_active |-> evt_reg)
		else $error("wake without event");
	a_deep_no_event: assert property (@(posedge i_clk) disable iff (!i_nrst)
		i_ce && i_sleeping && i_power_mode == `ST_MODE_PM3 |=> !evt_reg)
		else $error("event in deepest mode");
endmodule : sleep_wakeup_timer

// File: design/slow_tick_gen.sv
// Slow-clock edge detector and RC oscillator calibration model
`timescale 1ns/1ps
`include "sleep_timer_params.svh"
module slow_tick_gen (
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic i_ce,
	input wire logic i_xtal_clk,
	input wire logic i_rc_clk,
	input wire logic i_use_rc,
	input wire logic i_calibrate,
	sleep_tick_if.source tick_if
);
	logic sel_reg, sel_next;
	logic prev_reg, prev_next;
	logic cal_reg, cal_next;
	// ************************************************************
	// Edge detection and calibration hold
	// ************************************************************
	always_comb begin
		sel_next = i_use_rc ? i_rc_clk : i_xtal_clk;
		prev_next = sel_reg;
		// Calibration result is kept once gained, never lost in sleep
		// Calibration runs whenever allowed, whichever source is selected
		cal_next = cal_reg | i_calibrate;
	end
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			sel_reg <= 1'b0;
			prev_reg <= 1'b0;
			cal_reg <= 1'b0;
		end else if (i_ce) begin
			sel_reg <= sel_next;
			prev_reg <= prev_next;
			cal_reg <= cal_next;
		end
	end
	assign tick_if.tick = i_ce & sel_reg & ~prev_reg;
	assign tick_if.cal_valid = cal_reg;
endmodule : slow_tick_gen

// File: verification/slow_osc_model.sv
// Slow clock sources feeding the sleep timer
`timescale 1ns/1ps
module slow_osc_model #(
	parameter int XTAL_HALF = 8,
	parameter int RC_HALF = 6
) (
	input wire logic i_clk,
	output logic o_xtal_clk,
	output logic o_rc_clk
);
	int xc_reg = 0;
	int rc_reg = 0;
	initial begin
		o_xtal_clk = 1'b0;
		o_rc_clk = 1'b0;
	end
	// Both run free; scaled far down so a run stays short
	always @(posedge i_clk) begin
		xc_reg <= (xc_reg == XTAL_HALF - 1) ? 0 : xc_reg + 1;
		rc_reg <= (rc_reg == RC_HALF - 1) ? 0 : rc_reg + 1;
		if (xc_reg == XTAL_HALF - 1) o_xtal_clk <= ~o_xtal_clk;
		if (rc_reg == RC_HALF - 1) o_rc_clk <= ~o_rc_clk;
	end
endmodule : slow_osc_model

// File: verification/test_sleep_wakeup_timer.sv
// Self-checking bench of the sleep wake-up timer
`timescale 1ns/1ps
module test_sleep_wakeup_timer;
	logic i_clk = 1'b0, i_nrst = 1'b0, use_rc = 1'b0, hs_on = 1'b0, sleeping = 1'b0;
	logic clr = 1'b0, wie = 1'b0, cie = 1'b0, pclr = 1'b0, fclr = 1'b0, ce = 1'b1;
	logic [15:0] frozen;
	logic [1:0] pmode = 2'h0, res = 2'h0;
	logic [15:0] mant = 16'hFFFF;
	logic [7:0] lowb;
	logic [15:0] slice;
	logic pend, flag, irq, wake, evt, calv, xtal, rc;
	int failures = 0;
	int samples_checked = 0;
	int cycles = 0;
	int n;
	logic [3:0] notes[$];
	always #2.5 i_clk = ~i_clk;
	slow_osc_model slow_osc_model_i (.i_clk(i_clk), .o_xtal_clk(xtal), .o_rc_clk(rc));
	sleep_wakeup_timer sleep_wakeup_timer_i (.i_clk(i_clk), .i_nrst(i_nrst), .i_ce(ce),
		.i_xtal_clk(xtal), .i_rc_clk(rc), .i_use_rc(use_rc), .i_hs_xosc_on(hs_on),
		.i_sleeping(sleeping), .i_power_mode(pmode), .i_sleep_resolution_select(res),
		.i_wake_event_mantissa(mant), .i_counter_clear(clr),
		.i_wake_event_irq_enable(wie), .i_cpu_sleep_irq_enable(cie),
		.i_pending_clear(pclr), .i_cpu_flag_clear(fclr), .o_sleep_count_low_byte(lowb),
		.o_sleep_count_slice(slice), .o_wake_event_pending(pend),
		.o_cpu_sleep_irq_flag(flag), .o_irq(irq), .o_wake_to_active(wake),
		.o_event_pulse(evt), .o_rc_cal_valid(calv));
	// ****************
	// Shared tasks
	// ****************
	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : report_and_stop
	// Low byte change marks an aligned slow edge; bounded so a dead counter cannot hang
	task automatic wait_change(output int c);
		logic [7:0] t;
		t = lowb;
		c = 0;
		while (lowb === t && c < 20000) begin
			@(negedge i_clk);
			c++;
		end
	endtask : wait_change
	task automatic pulse_clear;
		@(posedge i_clk) clr <= 1'b1;
		@(posedge i_clk) clr <= 1'b0;
		// One half cycle only: a tick may follow the loading edge at once
		@(negedge i_clk);
	endtask : pulse_clear
	task automatic run_event(input logic [1:0] m, input logic r, input logic we, input logic ce);
		int k;
		k = 1 + $urandom % 4;
		@(posedge i_clk) begin
			pmode <= m;
			use_rc <= r;
			wie <= we;
			cie <= ce;
		end
		pulse_clear();
		wait_change(n);
		wait_change(n);
		// Event follows sleep within a few ticks, far under the 384-tick advice, to stay short
		@(posedge i_clk) begin
			mant <= 16'h0006 + 16'(k);
			sleeping <= 1'b1;
		end
		if (m != 2'h3) notes.push_back({1'b1, we, we & ce & (m == 2'h0), 1'b1});
		repeat ((k + 3) * 16) @(posedge i_clk);
		@(negedge i_clk);
		check("pending held", {15'h0, m != 2'h3}, {15'h0, pend});
		@(posedge i_clk) begin
			sleeping <= 1'b0;
			pclr <= 1'b1;
			fclr <= 1'b1;
		end
		@(posedge i_clk) begin
			pclr <= 1'b0;
			fclr <= 1'b0;
		end
		@(negedge i_clk) check("pending cleared", 16'h0, {15'h0, pend});
		$display("event test mode %0d done", m);
	endtask : run_event
	// ****************
	// Watchers
	// ****************
	always @(negedge i_clk) if (i_nrst && evt === 1'b1) begin
		if (notes.size() == 0) check("unexpected event", 16'h0, 16'h1);
		else check("event flags", {12'h0, notes.pop_front()}, {12'h0, pend, flag, irq, wake});
	end
	always @(posedge i_clk) begin
		cycles++;
		if (cycles == 60000) begin
			failures++;
			report_and_stop();
		end
	end
	// ****************
	// Main sequence
	// ****************
	initial begin
		void'($urandom(32'h9D808CEE));
		repeat (3) @(posedge i_clk);
		i_nrst <= 1'b1;
		@(negedge i_clk) check("pending after reset", 16'h0, {15'h0, pend});
		@(posedge i_clk) begin
			use_rc <= 1'b1;
			hs_on <= 1'b1;
		end
		repeat (64) @(negedge i_clk);
		check("rc calibrated", 16'h1, {15'h0, calv});
		@(posedge i_clk) use_rc <= 1'b0;
		pulse_clear();
		check("slice after clear", 16'h0004, slice);
		wait_change(n);
		check("slice first step", 16'h0005, slice);
		wait_change(n);
		check("slice step", 16'h0006, slice);
		$display("clear test done");
		@(posedge i_clk) res <= 2'h1;
		pulse_clear();
		wait_change(n);
		wait_change(n);
		check("res 1 interval", 16'h0200, 16'(n));
		check("res 1 slice", 16'h0002, slice);
		@(posedge i_clk) res <= 2'h0;
		$display("resolution test done");
		@(posedge i_clk) ce <= 1'b0;
		@(negedge i_clk) frozen = slice;
		repeat (40) @(negedge i_clk);
		check("frozen slice", frozen, slice);
		@(posedge i_clk) ce <= 1'b1;
		$display("clock enable test done");
		for (int i = 0; i < 8; i++) run_event(2'(i), 1'($urandom), 1'($urandom), 1'($urandom));
		report_and_stop();
	end
endmodule : test_sleep_wakeup_timer
